// >>> rtl/pie_irq_enable_flags.sv
`timescale 1ns/10ps
// Behaviour
// - Receive buffer 1 flag sets on a new message and holds until a flags write clears it.
// - Every peripheral source has its own enable bit, except the parallel port on the small package.
// - Enable bits live in three separate enable registers.
// - With priority scheme off, gate bit must be set for any request on enable1_req or periph_irq; irq is not gated.
// - Small package: parallel port enable reads zero, writes ignored.
`include "pie_defs.svh"

module pie_irq_enable_flags import pie_pkg::*; #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire pie_evt_s evt,
  input wire logic [7:0] enable1_src,
  output logic [7:0] enable1_req,
  output logic periph_irq,
  output logic irq
);

  initial begin
    if (SMALL_PACKAGE !== 1'b0 && SMALL_PACKAGE !== 1'b1) $error("bad SMALL_PACKAGE");
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic wr_q;
  logic [11:0] addr_q;
  logic wr_en;
  logic take_write;
  logic take_read;

  // Narrow writes complete OKAY but touch nothing: every register is one whole word
  assign take_write = hready && hsel && htrans[1] && hwrite && (hsize == 3'h2);
  assign take_read = hready && hsel && htrans[1] && !hwrite;

  // The write strobe waits for the data phase, where hwdata stands
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
    end else if (hready) begin
      wr_q <= take_write;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 12'h000;
    end else if (hready) begin
      addr_q <= haddr;
    end
  end

  assign wr_en = wr_q;
  // Zero wait states: the slave never stretches a transfer
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = {a[11:2], 2'b00} == r;
  endfunction : hit

  function automatic logic [31:0] zext8(input pie_byte_t v);
    zext8 = {24'h000000, v};
  endfunction : zext8

  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  logic wr_flags3;
  logic wr_en1;
  logic wr_en2;
  logic wr_en3;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;

  assign wr_flags3 = wr_en && hit(addr_q, `PIE_ADDR_FLAGS3);
  assign wr_en1 = wr_en && hit(addr_q, `PIE_ADDR_EN1);
  assign wr_en2 = wr_en && hit(addr_q, `PIE_ADDR_EN2);
  assign wr_en3 = wr_en && hit(addr_q, `PIE_ADDR_EN3);
  assign wr_ctrl = wr_en && hit(addr_q, `PIE_ADDR_CTRL);
  assign wr_stat = wr_en && hit(addr_q, `PIE_ADDR_IRQ_STAT);
  assign wr_mask = wr_en && hit(addr_q, `PIE_ADDR_IRQ_MASK);

  // ----------------------------------------
  // Flag and enable registers
  // ----------------------------------------
  pie_byte_t flags3_q;
  pie_byte_t en1_q;
  pie_byte_t en2_q;
  pie_byte_t en3_q;
  pie_byte_t ctrl_q;
  logic [`PIE_IRQ_BITS-1:0] stat_q;
  logic [`PIE_IRQ_BITS-1:0] mask_q;
  logic [7:0] evt_bits;
  logic [7:0] en1_wmask;

  assign evt_bits = {5'h00, evt.tx_buf0_done, evt.rx_buf1_msg, evt.rx_buf0_msg};
  // Parallel port enable bit is absent on the small package
  assign en1_wmask = SMALL_PACKAGE ? ~(8'h01 << `PIE_BIT_PARPORT) : 8'hFF;

  // Set wins over a software clear in the same cycle; flags latch whatever the enables hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags3_q <= `PIE_RST_FLAGS3;
    end else if (wr_flags3) begin
      flags3_q <= (hwdata[7:0] & `PIE_FLAG_MASK) | evt_bits;
    end else begin
      flags3_q <= flags3_q | evt_bits;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en1_q <= `PIE_RST_EN1;
    end else if (wr_en1) begin
      en1_q <= hwdata[7:0] & en1_wmask;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en2_q <= `PIE_RST_EN2;
    end else if (wr_en2) begin
      en2_q <= hwdata[7:0];
    end
  end

  // Enable register 3 comes out of reset all ones, so buffer flags pass once the gate opens
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en3_q <= `PIE_RST_EN3;
    end else if (wr_en3) begin
      en3_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `PIE_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= {6'h00, hwdata[1:0]};
    end
  end

  // ----------------------------------------
  // Request gating
  // ----------------------------------------
  logic gate_ok;
  logic [2:0] buf_req;
  logic [7:0] en1_hits;

  assign gate_ok = ctrl_q[`PIE_BIT_PRIO] || ctrl_q[`PIE_BIT_GATE];
  assign buf_req = flags3_q[2:0] & en3_q[2:0];
  assign en1_hits = enable1_src & en1_q;
  assign enable1_req = gate_ok ? en1_hits : 8'h00;
  assign periph_irq = gate_ok && ((|buf_req) || (|en1_hits));

  // ----------------------------------------
  // Block interrupt status, write one to clear
  // ----------------------------------------
  // An event in the clearing cycle survives, so no event is lost to a late clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= 3'h0;
    end else if (wr_stat) begin
      stat_q <= (stat_q & ~hwdata[2:0]) | evt_bits[2:0];
    end else begin
      stat_q <= stat_q | evt_bits[2:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= 3'h0;
    end else if (wr_mask) begin
      mask_q <= hwdata[2:0];
    end
  end

  assign irq = |(stat_q & mask_q);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case ({haddr[11:2], 2'b00})
      `PIE_ADDR_FLAGS3: rd_mux = zext8(flags3_q);
      `PIE_ADDR_EN1: rd_mux = zext8(en1_q);
      `PIE_ADDR_EN2: rd_mux = zext8(en2_q);
      `PIE_ADDR_EN3: rd_mux = zext8(en3_q);
      `PIE_ADDR_CTRL: rd_mux = zext8(ctrl_q);
      `PIE_ADDR_IRQ_STAT: rd_mux = {29'h00000000, stat_q};
      `PIE_ADDR_IRQ_MASK: rd_mux = {29'h00000000, mask_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Captured in the address phase so the word stands through the whole data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take_read) begin
      hrdata <= rd_mux;
    end
  end

endmodule : pie_irq_enable_flags

// >>> rtl/pie_defs.svh
`ifndef PIE_DEFS_SVH
`define PIE_DEFS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PIE_ADDR_FLAGS3 12'h000
`define PIE_ADDR_EN1 12'h004
`define PIE_ADDR_EN2 12'h008
`define PIE_ADDR_EN3 12'h00C
`define PIE_ADDR_CTRL 12'h010
`define PIE_ADDR_IRQ_STAT 12'h014
`define PIE_ADDR_IRQ_MASK 12'h018

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PIE_BIT_RXB0 0
`define PIE_BIT_RXB1 1
`define PIE_BIT_TXB0 2
`define PIE_BIT_PARPORT 7
`define PIE_BIT_PRIO 0
`define PIE_BIT_GATE 1
`define PIE_RST_FLAGS3 8'h00
`define PIE_RST_EN1 8'h00
`define PIE_RST_EN2 8'h00
`define PIE_RST_EN3 8'hFF
`define PIE_RST_CTRL 8'h00
`define PIE_FLAG_MASK 8'h07
`define PIE_IRQ_BITS 3

`endif

// >>> rtl/pie_pkg.sv
package pie_pkg;
  typedef logic [7:0] pie_byte_t;
  typedef struct packed {
    logic tx_buf0_done;
    logic rx_buf1_msg;
    logic rx_buf0_msg;
  } pie_evt_s;
endpackage : pie_pkg

// >>> tb/pie_irq_enable_flags_chk.sv
`timescale 1ns/10ps
`include "pie_defs.svh"
module pie_irq_enable_flags_chk import pie_pkg::*; #(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire pie_evt_s evt,
  input wire logic [7:0] enable1_src,
  input wire logic [7:0] enable1_req,
  input wire logic periph_irq,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rx1_event;
    evt.rx_buf1_msg;
  endsequence
  sequence s_flags_read;
    hsel && htrans[1] && !hwrite && hreadyout && (haddr == `PIE_ADDR_FLAGS3);
  endsequence
  a_rx1_flag_read: assert property (s_rx1_event ##[1:2] s_flags_read |=> hrdata[`PIE_BIT_RXB1])
    else $error("receive buffer 1 event not seen in flags");
  a_ready_high: assert property (hreadyout)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (!hresp)
    else $error("slave answered with an error");
  a_irq_reset_low: assert property ($rose(hresetn) |-> (!irq && (enable1_req == 8'h00)))
    else $error("request active right after reset");
  a_req_needs_src: assert property ((enable1_req & ~enable1_src) == 8'h00)
    else $error("request without source");
  a_small_pkg_off: assert property (SMALL_PACKAGE |-> !enable1_req[7])
    else $error("parallel port request on small package");
  a_req_drives_irq: assert property ((|enable1_req) |-> periph_irq)
    else $error("enabled request not reaching core");
endmodule : pie_irq_enable_flags_chk
bind pie_irq_enable_flags pie_irq_enable_flags_chk #(.SMALL_PACKAGE(SMALL_PACKAGE)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .evt(evt), .enable1_src(enable1_src), .enable1_req(enable1_req),
  .periph_irq(periph_irq), .irq(irq));

// >>> tb/pie_src_model.sv
`timescale 1ns/10ps
module pie_src_model import pie_pkg::*; (
  input wire logic hclk,
  input wire logic [2:0] fire,
  output pie_evt_s evt
);
  // Registered so each event is a clean one-cycle pulse on the design clock
  always_ff @(posedge hclk) evt <= fire;
endmodule : pie_src_model

// >>> tb/tb_pie_irq_enable_flags.sv
`timescale 1ns/10ps
`include "pie_defs.svh"
module tb_pie_irq_enable_flags import pie_pkg::*;;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hrdy, hresp, pirq, irq;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] fire = 0;
  logic [31:0] hwdata = 0, hrdata, r;
  logic [7:0] src = 0, req;
  pie_evt_s evt;
  int err_total = 0, n_tests = 0;
  always #20 hclk = ~hclk;
  pie_src_model src_u (.hclk(hclk), .fire(fire), .evt(evt));
  pie_irq_enable_flags #(.SMALL_PACKAGE(1'b1)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .evt(evt), .enable1_src(src),
    .enable1_req(req), .periph_irq(pirq), .irq(irq));
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hrdy !== 1'b1);
    r = hrdata;
    // One idle cycle lets a written register settle the outputs before a compare
    @(posedge hclk);
  endtask : xfer
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task chk_bit(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_bit
  task rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(r, e);
  endtask : rd
  task pulse(input logic [2:0] v);
    fire <= v;
    @(posedge hclk);
    fire <= 3'h0;
    repeat (2) @(posedge hclk);
  endtask : pulse
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    #40000; err_total++; complete_run;
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`PIE_ADDR_EN1, 32'h0);
    rd(`PIE_ADDR_FLAGS3, 32'h0);
    rd(`PIE_ADDR_EN3, 32'hFF);
    rd(12'h01C, 32'h0);
    $display("test reset done");
    pulse(3'h2);
    rd(`PIE_ADDR_FLAGS3, 32'h2);
    chk_bit(pirq, 1'b0);
    xfer(1'b1, `PIE_ADDR_CTRL, 32'h2);
    chk_bit(pirq, 1'b1);
    xfer(1'b1, `PIE_ADDR_EN3, 32'hFD);
    chk_bit(pirq, 1'b0);
    $display("test gate done");
    xfer(1'b1, `PIE_ADDR_EN1, 32'hFF);
    src <= 8'hFF;
    @(posedge hclk);
    chk(req, 8'h7F);
    rd(`PIE_ADDR_EN1, 32'h7F);
    xfer(1'b1, `PIE_ADDR_CTRL, 32'h0);
    chk(req, 8'h00);
    $display("test enable done");
    pulse(3'h1);
    chk_bit(irq, 1'b0);
    rd(`PIE_ADDR_FLAGS3, 32'h3);
    xfer(1'b1, `PIE_ADDR_IRQ_MASK, 32'h1);
    chk_bit(irq, 1'b1);
    xfer(1'b1, `PIE_ADDR_IRQ_STAT, 32'h1);
    chk_bit(irq, 1'b0);
    $display("test interrupt done");
    complete_run;
  end
endmodule : tb_pie_irq_enable_flags
